// [verilog/tql_speed_loop.sv]
`timescale 1ns/1ps
`default_nettype none
module tql_speed_loop
  import tql_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire tql_bus_req_t       bus_req,
  output logic [15:0]             rd_data,
  input  wire logic               speed_sample_req,
  input  wire logic signed [15:0] speed_fbk_raw,
  output logic signed [15:0]      current_cmd,
  output logic                    current_cmd_valid,
  output logic signed [15:0]      raw_speed_probe,
  output logic signed [15:0]      filt_speed
);

  // ***************************************************
  // Helpers
  // ***************************************************
  // Symmetric saturation of a wide value to +/-lim
  function automatic logic signed [15:0] tql_sat(
    input logic signed [33:0] v,
    input logic signed [15:0] lim
  );
    if (v > 34'(lim)) begin
      tql_sat = lim;
    end else if (v < -34'(lim)) begin
      tql_sat = -lim;
    end else begin
      tql_sat = v[15:0];
    end
  endfunction

  // ***************************************************
  // Register file state
  // ***************************************************
  logic [3:0]         ctrl_ff, nxt_ctrl;         // Mode and option bits
  logic signed [15:0] trq_ff, nxt_trq;           // Torque command
  logic signed [15:0] spdref_ff, nxt_spdref;     // Speed reference
  logic [15:0]        kp_ff, nxt_kp;             // Proportional gain
  logic [15:0]        ki_ff, nxt_ki;             // Integral gain
  logic signed [15:0] stceil_ff, nxt_stceil;     // Startup ceiling
  logic signed [15:0] rgceil_ff, nxt_rgceil;     // Regen ceiling
  logic signed [15:0] mtceil_ff, nxt_mtceil;     // Motoring ceiling
  logic signed [15:0] lowb_ff, nxt_lowb;         // Limiter lower bound
  logic [3:0]         dlim_ff, nxt_dlim;         // Difference bound exp
  logic [3:0]         fshift_ff, nxt_fshift;     // Filter shift
  logic [15:0]        rstep_ff, nxt_rstep;       // Ramp step per sample
  logic [15:0]        rdata_ff, nxt_rdata;       // Read data

  // ***************************************************
  // Datapath state
  // ***************************************************
  logic signed [15:0] prev_ff, nxt_prev;         // Previous filter input
  logic signed [15:0] filt_ff, nxt_filt;         // Filtered speed
  logic signed [15:0] integ_ff, nxt_integ;       // Integrator
  logic signed [15:0] pi_ff, nxt_pi;             // Regulator output
  logic signed [15:0] ramp_ff, nxt_ramp;         // Change-over ramp
  logic signed [15:0] cmd_ff, nxt_cmd;           // Limited command
  logic signed [15:0] raw_ff, nxt_raw;           // Raw speed tap
  logic               vld_ff, nxt_vld;           // Command strobe
  tql_mode_t          mode_ff, nxt_mode;         // Selector state

  // ***************************************************
  // Register file next state
  // ***************************************************
  // Writes take effect at the next edge; reads answer one cycle on
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_trq    = trq_ff;
    nxt_spdref = spdref_ff;
    nxt_kp     = kp_ff;
    nxt_ki     = ki_ff;
    nxt_stceil = stceil_ff;
    nxt_rgceil = rgceil_ff;
    nxt_mtceil = mtceil_ff;
    nxt_lowb   = lowb_ff;
    nxt_dlim   = dlim_ff;
    nxt_fshift = fshift_ff;
    nxt_rstep  = rstep_ff;
    nxt_rdata  = 16'h0000;
    if (bus_req.wr) begin
      case (bus_req.addr)
        TQL_OFS_CTRL:   nxt_ctrl   = bus_req.wdata[3:0];
        // Out-of-range requests clip to rated current
        TQL_OFS_TRQ:    nxt_trq    = tql_sat(34'(signed'(bus_req.wdata)),
                                             TQL_FULL_SCALE);
        TQL_OFS_SPDREF: nxt_spdref = bus_req.wdata;
        TQL_OFS_KP:     nxt_kp     = bus_req.wdata;
        TQL_OFS_KI:     nxt_ki     = bus_req.wdata;
        TQL_OFS_STCEIL: nxt_stceil = bus_req.wdata;
        TQL_OFS_RGCEIL: nxt_rgceil = bus_req.wdata;
        TQL_OFS_MTCEIL: nxt_mtceil = bus_req.wdata;
        TQL_OFS_LOWB:   nxt_lowb   = bus_req.wdata;
        TQL_OFS_DLIM:   nxt_dlim   = bus_req.wdata[3:0];
        TQL_OFS_FSHIFT: nxt_fshift = bus_req.wdata[3:0];
        TQL_OFS_RSTEP:  nxt_rstep  = bus_req.wdata;
        default: ;  // Unmapped writes are dropped
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        TQL_OFS_CTRL:   nxt_rdata = {12'h000, ctrl_ff};
        TQL_OFS_TRQ:    nxt_rdata = trq_ff;
        TQL_OFS_SPDREF: nxt_rdata = spdref_ff;
        TQL_OFS_KP:     nxt_rdata = kp_ff;
        TQL_OFS_KI:     nxt_rdata = ki_ff;
        TQL_OFS_STCEIL: nxt_rdata = stceil_ff;
        TQL_OFS_RGCEIL: nxt_rdata = rgceil_ff;
        TQL_OFS_MTCEIL: nxt_rdata = mtceil_ff;
        TQL_OFS_LOWB:   nxt_rdata = lowb_ff;
        TQL_OFS_DLIM:   nxt_rdata = {12'h000, dlim_ff};
        TQL_OFS_FSHIFT: nxt_rdata = {12'h000, fshift_ff};
        TQL_OFS_RSTEP:  nxt_rdata = rstep_ff;
        TQL_OFS_RAWSPD: nxt_rdata = raw_ff;
        TQL_OFS_FILT:   nxt_rdata = filt_ff;
        TQL_OFS_CMD:    nxt_rdata = cmd_ff;
        TQL_OFS_STAT:   nxt_rdata = {14'h0000, mode_ff};
        default:        nxt_rdata = 16'h0000;    // Unmapped reads zero
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff   <= TQL_CTRL_RST;
      trq_ff    <= 16'sh0000;
      spdref_ff <= 16'sh0000;
      kp_ff     <= 16'h0000;
      ki_ff     <= 16'h0000;
      stceil_ff <= TQL_CEIL_RST;
      rgceil_ff <= TQL_CEIL_RST;
      mtceil_ff <= TQL_CEIL_RST;
      lowb_ff   <= TQL_LOWB_RST;
      dlim_ff   <= TQL_DLIM_RST;
      fshift_ff <= TQL_FSHIFT_RST;
      rstep_ff  <= TQL_RSTEP_RST;
      rdata_ff  <= 16'h0000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      trq_ff    <= nxt_trq;
      spdref_ff <= nxt_spdref;
      kp_ff     <= nxt_kp;
      ki_ff     <= nxt_ki;
      stceil_ff <= nxt_stceil;
      rgceil_ff <= nxt_rgceil;
      mtceil_ff <= nxt_mtceil;
      lowb_ff   <= nxt_lowb;
      dlim_ff   <= nxt_dlim;
      fshift_ff <= nxt_fshift;
      rstep_ff  <= nxt_rstep;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ***************************************************
  // Loop datapath
  // ***************************************************
  logic signed [33:0] diff;       // New input minus previous
  logic signed [33:0] bound;      // 2^limit
  logic signed [15:0] lim_in;     // Bounded filter input
  logic signed [33:0] err;        // Speed error
  logic signed [33:0] prop;       // Proportional term
  logic signed [15:0] sel;        // Selector output
  logic signed [15:0] upper;      // Active current ceiling
  logic signed [33:0] rdelta;     // Ramp distance to target

  // One whole loop update per sample request, registered at once
  always_comb begin
    nxt_prev  = prev_ff;
    nxt_filt  = filt_ff;
    nxt_integ = integ_ff;
    nxt_pi    = pi_ff;
    nxt_ramp  = ramp_ff;
    nxt_cmd   = cmd_ff;
    nxt_raw   = raw_ff;
    nxt_mode  = mode_ff;
    nxt_vld   = 1'b0;
    diff   = 34'(speed_fbk_raw) - 34'(prev_ff);
    bound  = 34'sh000000001 <<< dlim_ff;
    lim_in = speed_fbk_raw;
    // Only the filter input is bounded; the tap keeps the raw value
    if (ctrl_ff[TQL_BIT_DLEN]) begin
      if (diff > bound) begin
        lim_in = tql_sat(34'(prev_ff) + bound, TQL_WORD_MAX);
      end else if (diff < -bound) begin
        lim_in = tql_sat(34'(prev_ff) - bound, TQL_WORD_MAX);
      end
    end
    err  = 34'(spdref_ff) - 34'(filt_ff);
    prop = (err * $signed({18'h00000, kp_ff})) >>> TQL_PI_FRAC;
    rdelta = 34'(trq_ff) - 34'(ramp_ff);
    sel    = pi_ff;
    upper  = mtceil_ff;
    if (speed_sample_req) begin
      nxt_vld  = 1'b1;
      nxt_raw  = speed_fbk_raw;
      nxt_prev = lim_in;
      nxt_filt = tql_sat(((34'(lim_in) - 34'(filt_ff)) >>> fshift_ff)
                         + 34'(filt_ff), TQL_WORD_MAX);
      // Zero gains hold the output at zero for the lower-bound scheme
      nxt_integ = tql_sat(34'(integ_ff) + ((err *
                  $signed({18'h00000, ki_ff})) >>> TQL_PI_FRAC),
                  TQL_WORD_MAX);
      nxt_pi = tql_sat(34'(nxt_integ) + prop, TQL_WORD_MAX);
      // Selector sits after the regulator, before the limiter
      case (mode_ff)
        TQL_SPEED: begin
          if (!ctrl_ff[TQL_BIT_MODE]) begin
            // Ramp seeded from regulator so the command does not jump
            nxt_ramp = nxt_pi;
            nxt_mode = ctrl_ff[TQL_BIT_RAMP] ? TQL_RAMP : TQL_TORQUE;
          end
        end
        TQL_RAMP: begin
          if (rdelta > 34'($signed({1'b0, rstep_ff[14:0]}))) begin
            nxt_ramp = tql_sat(34'(ramp_ff) + 34'(rstep_ff),
                               TQL_WORD_MAX);
          end else if (rdelta < -34'($signed({1'b0, rstep_ff[14:0]})))
          begin
            nxt_ramp = tql_sat(34'(ramp_ff) - 34'(rstep_ff),
                               TQL_WORD_MAX);
          end else begin
            nxt_ramp = trq_ff;
            nxt_mode = TQL_TORQUE;
          end
          if (ctrl_ff[TQL_BIT_MODE]) begin
            nxt_mode = TQL_SPEED;
          end
        end
        TQL_TORQUE: begin
          if (ctrl_ff[TQL_BIT_MODE]) begin
            nxt_mode = TQL_SPEED;
          end
        end
        default: nxt_mode = TQL_SPEED;
      endcase
      // Torque request passes straight; no overspeed guard here
      if (ctrl_ff[TQL_BIT_MODE]) begin
        sel = nxt_pi;
      end else if (mode_ff == TQL_RAMP || nxt_mode == TQL_RAMP) begin
        sel = nxt_ramp;
      end else begin
        sel = trq_ff;
      end
      // Ceiling chosen alike in both modes
      if (ctrl_ff[TQL_BIT_START]) begin
        upper = stceil_ff;
      end else if ((sel < 0) != (nxt_filt < 0)) begin
        upper = rgceil_ff;
      end else begin
        upper = mtceil_ff;
      end
      if (sel > upper) begin
        nxt_cmd = upper;
      end else if (sel < lowb_ff) begin
        nxt_cmd = lowb_ff;
      end else begin
        nxt_cmd = sel;
      end
    end
  end

  // Datapath flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_ff  <= 16'sh0000;
      filt_ff  <= 16'sh0000;
      integ_ff <= 16'sh0000;
      pi_ff    <= 16'sh0000;
      ramp_ff  <= 16'sh0000;
      cmd_ff   <= 16'sh0000;
      raw_ff   <= 16'sh0000;
      vld_ff   <= 1'b0;
      mode_ff  <= TQL_SPEED;
    end else begin
      prev_ff  <= nxt_prev;
      filt_ff  <= nxt_filt;
      integ_ff <= nxt_integ;
      pi_ff    <= nxt_pi;
      ramp_ff  <= nxt_ramp;
      cmd_ff   <= nxt_cmd;
      raw_ff   <= nxt_raw;
      vld_ff   <= nxt_vld;
      mode_ff  <= nxt_mode;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign rd_data           = rdata_ff;
  assign current_cmd       = cmd_ff;
  assign current_cmd_valid = vld_ff;
  assign raw_speed_probe   = raw_ff;
  assign filt_speed        = filt_ff;

endmodule // tql_speed_loop
`default_nettype wire

// [shared/tql_pkg.sv]
// Overview of operation
// - Mode select 0 torque, 1 speed
// - Selector between speed regulator and limiter
// - Current ceilings clamp in both modes
// - Torque command full scale 4095 rated
// - Torque mode adds no speed limiting
// - Filter input step bounded to 2^limit
// - Bound only on filter path
// - Raw speed exposed on observation tap
// - Mode change ramp starts from regulator
package tql_pkg;

  // ***************************************************
  // Register map (byte addresses)
  // ***************************************************
  localparam int          TQL_AW          = 8;
  localparam int          TQL_DW          = 16;
  localparam logic [7:0]  TQL_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  TQL_OFS_TRQ     = 8'h04;
  localparam logic [7:0]  TQL_OFS_SPDREF  = 8'h08;
  localparam logic [7:0]  TQL_OFS_KP      = 8'h0C;
  localparam logic [7:0]  TQL_OFS_KI      = 8'h10;
  localparam logic [7:0]  TQL_OFS_STCEIL  = 8'h14;
  localparam logic [7:0]  TQL_OFS_RGCEIL  = 8'h18;
  localparam logic [7:0]  TQL_OFS_MTCEIL  = 8'h1C;
  localparam logic [7:0]  TQL_OFS_LOWB    = 8'h20;
  localparam logic [7:0]  TQL_OFS_DLIM    = 8'h24;
  localparam logic [7:0]  TQL_OFS_FSHIFT  = 8'h28;
  localparam logic [7:0]  TQL_OFS_RSTEP   = 8'h2C;
  localparam logic [7:0]  TQL_OFS_RAWSPD  = 8'h30;
  localparam logic [7:0]  TQL_OFS_FILT    = 8'h34;
  localparam logic [7:0]  TQL_OFS_CMD     = 8'h38;
  localparam logic [7:0]  TQL_OFS_STAT    = 8'h3C;

  // ***************************************************
  // Control register fields
  // ***************************************************
  localparam int TQL_BIT_MODE  = 0;  // Control mode select
  localparam int TQL_BIT_DLEN  = 1;  // Difference bound enable
  localparam int TQL_BIT_RAMP  = 2;  // Smooth change-over enable
  localparam int TQL_BIT_START = 3;  // Startup phase active

  // ***************************************************
  // Reset values and scaling
  // ***************************************************
  localparam logic [3:0]         TQL_CTRL_RST   = 4'h1;
  localparam logic signed [15:0] TQL_FULL_SCALE = 16'sh0FFF;
  localparam logic signed [15:0] TQL_WORD_MAX   = 16'sh7FFF;
  localparam logic signed [15:0] TQL_CEIL_RST   = 16'sh0FFF;
  localparam logic signed [15:0] TQL_LOWB_RST   = 16'shF001;
  localparam logic [3:0]         TQL_DLIM_RST   = 4'h8;
  localparam logic [3:0]         TQL_FSHIFT_RST = 4'h4;
  localparam logic [15:0]        TQL_RSTEP_RST  = 16'h0010;
  localparam int                 TQL_PI_FRAC    = 8;

  // ***************************************************
  // Types
  // ***************************************************
  typedef struct packed {
    logic [7:0]  addr;   // Byte address
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } tql_bus_req_t;

  typedef enum logic [1:0] {
    TQL_SPEED,
    TQL_RAMP,
    TQL_TORQUE
  } tql_mode_t;

endpackage

// [verif/tql_speed_loop_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module tql_speed_loop_chk
  import tql_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire tql_bus_req_t       bus_req,
  input wire logic [15:0]        rd_data,
  input wire logic               speed_sample_req,
  input wire logic signed [15:0] speed_fbk_raw,
  input wire logic signed [15:0] current_cmd,
  input wire logic               current_cmd_valid,
  input wire logic signed [15:0] raw_speed_probe,
  input wire logic signed [15:0] filt_speed
);
  // ****************************************
  // Register mirror
  // ****************************************
  logic [15:0]        sh_ff [0:15]; // Copy of writable words
  logic [15:0]        rd_exp;       // Word the read should return
  logic signed [15:0] wd;           // Write data, signed view
  logic signed [15:0] trq;          // Torque command word
  logic signed [15:0] lowb;         // Limiter lower bound
  logic signed [15:0] cmin;         // Lowest of the three ceilings
  logic signed [15:0] cmax;         // Highest of the three ceilings
  logic [3:0]         ctl;          // Control bits

  // Derived views; min and max avoid modelling ceiling choice
  always_comb begin
    wd     = bus_req.wdata;
    rd_exp = sh_ff[bus_req.addr[5:2]];
    trq    = sh_ff[1];
    lowb   = sh_ff[8];
    ctl    = sh_ff[0][3:0];
    cmin   = sh_ff[5];
    cmax   = sh_ff[5];
    for (int i = 6; i < 8; i++) begin
      if ($signed(sh_ff[i]) < cmin) cmin = sh_ff[i];
      if ($signed(sh_ff[i]) > cmax) cmax = sh_ff[i];
    end
  end

  // Track writes; narrow fields masked, torque word clipped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) sh_ff[i] <= 16'h0000;
      sh_ff[0]  <= {12'h000, TQL_CTRL_RST};
      for (int i = 5; i < 8; i++) sh_ff[i] <= TQL_CEIL_RST;
      sh_ff[8]  <= TQL_LOWB_RST;
      sh_ff[9]  <= {12'h000, TQL_DLIM_RST};
      sh_ff[10] <= {12'h000, TQL_FSHIFT_RST};
      sh_ff[11] <= TQL_RSTEP_RST;
    end else if (bus_req.wr && bus_req.addr <= TQL_OFS_RSTEP
                 && bus_req.addr[1:0] == 2'b00) begin
      case (bus_req.addr[5:2])
        4'h0, 4'h9, 4'hA: sh_ff[bus_req.addr[5:2]] <= {12'h000, wd[3:0]};
        4'h1: sh_ff[1] <= (wd > TQL_FULL_SCALE) ? TQL_FULL_SCALE :
                          (wd < -TQL_FULL_SCALE) ? -TQL_FULL_SCALE : wd;
        default: sh_ff[bus_req.addr[5:2]] <= wd;
      endcase
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_VALID: assert property (
    current_cmd_valid == $past(speed_sample_req))
    else $error("valid pulse not one cycle after request");
  AST_PROBE: assert property (
    speed_sample_req |=> raw_speed_probe == $past(speed_fbk_raw))
    else $error("raw probe differs from sampled feedback");
  AST_HOLD: assert property (
    !speed_sample_req |=> $stable(current_cmd) && $stable(filt_speed))
    else $error("outputs moved without a request");
  AST_LOWB: assert property (
    current_cmd_valid |-> current_cmd >= $past(lowb))
    else $error("command below lower bound");
  AST_CEIL: assert property (
    current_cmd_valid |->
      current_cmd <= $past(cmax) || current_cmd == $past(lowb))
    else $error("command above every ceiling");
  AST_TORQUE: assert property (
    speed_sample_req && !ctl[0] && !ctl[2] && trq >= lowb && trq <= cmin
      |=> current_cmd == $past(trq))
    else $error("torque command not passed through");
  AST_RD_IDLE: assert property (
    !$past(bus_req.rd) |-> rd_data == 16'h0000)
    else $error("read data outside its cycle");
  AST_RD_RW: assert property (
    bus_req.rd && bus_req.addr <= TQL_OFS_RSTEP && bus_req.addr[1:0] == 2'b00
      |=> rd_data == $past(rd_exp))
    else $error("register readback mismatch");
  AST_RD_UNMAP: assert property (
    bus_req.rd && bus_req.addr > TQL_OFS_STAT |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_RAW: assert property (
    bus_req.rd && bus_req.addr == TQL_OFS_RAWSPD
      |=> rd_data == $past(raw_speed_probe))
    else $error("raw speed readback mismatch");

  // Main scenarios reached
  COV_TORQUE: cover property (speed_sample_req && !ctl[0]);
  COV_RAMP: cover property (speed_sample_req && ctl[2]);
  COV_UNMAP: cover property (bus_req.rd && bus_req.addr > TQL_OFS_STAT);
endmodule // tql_speed_loop_chk
`default_nettype wire

// [verif/test_tql_speed_loop.sv]
`timescale 1ns/1ps
`default_nettype none
module test_tql_speed_loop
  import tql_pkg::*;
;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic               clk_sys;           // 20 MHz clock
  logic               rst_b;             // Reset, active low
  tql_bus_req_t       bus_req;           // Register request
  logic [15:0]        rd_data;           // Read data
  logic               speed_sample_req;  // Loop update pulse
  logic signed [15:0] speed_fbk_raw;     // Raw feedback
  logic signed [15:0] current_cmd;       // Limited command
  logic               current_cmd_valid; // Update pulse
  logic signed [15:0] raw_speed_probe;   // Raw tap
  logic signed [15:0] filt_speed;        // Filtered speed
  int                 failures;          // Mismatch count
  int                 n_tests;           // Comparison count
  logic [15:0]        rv;                // Read result
  // Rows: ctrl, torque, lower bound, expected command
  logic [63:0] rows [8] = '{64'h0000_0100_FE00_0100,
    64'h0000_0700_FE00_0500, 64'h0000_FF00_FE00_FF00,
    64'h0000_FC00_FE00_FE00, 64'h0000_F000_F000_F001,
    64'h0008_0400_FE00_0200, 64'h0001_0400_0100_0100,
    64'h0001_0400_FE00_0000};
  // Filter rows: ctrl, feedback, expected filter value
  logic [47:0] frows [5] = '{48'h0003_0100_0004, 48'h0003_FF00_0000,
    48'h0003_0004_0004, 48'h0001_0100_0100, 48'h0003_00F0_00FC};

  tql_speed_loop i_tql_speed_loop (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus_req(bus_req), .rd_data(rd_data),
    .speed_sample_req(speed_sample_req), .speed_fbk_raw(speed_fbk_raw),
    .current_cmd(current_cmd), .current_cmd_valid(current_cmd_valid),
    .raw_speed_probe(raw_speed_probe), .filt_speed(filt_speed));

  // Free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  // Read data is taken only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  // One loop update; valid must stand in the next cycle
  task automatic samp(input logic [15:0] f);
    @(posedge clk_sys);
    speed_sample_req <= 1'b1;
    speed_fbk_raw    <= f;
    @(posedge clk_sys);
    speed_sample_req <= 1'b0;
    #1 chk({15'h0000, current_cmd_valid}, 16'h0001);
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the 160 or so cycles expected
  initial begin
    #500000;
    failures++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures = 0;
    n_tests = 0;
    rst_b = 1'b0;
    bus_req = '0;
    speed_sample_req = 1'b0;
    speed_fbk_raw = 16'sh0000;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(TQL_OFS_CTRL, rv);
    chk(rv, {12'h000, TQL_CTRL_RST});
    rd(TQL_OFS_LOWB, rv);
    chk(rv, TQL_LOWB_RST);
    wr(TQL_OFS_STCEIL, 16'h0200);
    wr(TQL_OFS_RGCEIL, 16'h0300);
    wr(TQL_OFS_MTCEIL, 16'h0500);
    foreach (rows[i]) begin
      wr(TQL_OFS_CTRL, rows[i][63:48]);
      wr(TQL_OFS_TRQ, rows[i][47:32]);
      wr(TQL_OFS_LOWB, rows[i][31:16]);
      samp(16'h0000);
      chk(current_cmd, rows[i][15:0]);
    end
    // Step bound of 4, filter passes its input straight
    wr(TQL_OFS_DLIM, 16'h0002);
    wr(TQL_OFS_FSHIFT, 16'h0000);
    foreach (frows[i]) begin
      wr(TQL_OFS_CTRL, frows[i][47:32]);
      samp(frows[i][31:16]);
      chk(filt_speed, frows[i][15:0]);
      chk(raw_speed_probe, frows[i][31:16]);
    end
    // Regulator gives 0x0100, then ramp toward 0x0140
    wr(TQL_OFS_CTRL, 16'h0001);
    samp(16'h0000);
    wr(TQL_OFS_SPDREF, 16'h0100);
    wr(TQL_OFS_KP, 16'h0100);
    samp(16'h0000);
    chk(current_cmd, 16'h0100);
    wr(TQL_OFS_TRQ, 16'h0140);
    wr(TQL_OFS_CTRL, 16'h0004);
    samp(16'h0000);
    // Ramp seed is the regulator output, so no step on change-over
    chk(current_cmd, 16'h0100);
    rd(TQL_OFS_STAT, rv);
    chk(rv, 16'h0001);
    repeat (8) samp(16'h0000);
    chk(current_cmd, 16'h0140);
    rd(TQL_OFS_STAT, rv);
    chk(rv, 16'h0002);
    samp(16'h4000);
    chk(current_cmd, 16'h0140);
    rd(TQL_OFS_RAWSPD, rv);
    chk(rv, 16'h4000);
    rd(8'h40, rv);
    chk(rv, 16'h0000);
    wr(TQL_OFS_CMD, 16'h1234);
    rd(TQL_OFS_CMD, rv);
    chk(rv, 16'h0140);
    // Reverse speed with forward torque picks the regen ceiling
    wr(TQL_OFS_TRQ, 16'h0400);
    samp(16'hC000);
    chk(current_cmd, 16'h0300);
    chk(filt_speed, 16'hC000);
    // Reset in mid-run clears outputs and restores settings to reset values
    @(posedge clk_sys);
    rst_b <= 1'b0;
    #1 chk(current_cmd, 16'h0000);
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(TQL_OFS_CTRL, rv);
    chk(rv, {12'h000, TQL_CTRL_RST});
    wrap_up();
  end
endmodule // test_tql_speed_loop

bind tql_speed_loop tql_speed_loop_chk i_tql_speed_loop_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
  .speed_sample_req(speed_sample_req), .speed_fbk_raw(speed_fbk_raw),
  .current_cmd(current_cmd), .current_cmd_valid(current_cmd_valid),
  .raw_speed_probe(raw_speed_probe), .filt_speed(filt_speed));
`default_nettype wire
